/* File: rtl/tscp_map.svh */
// Register offsets, field positions, reset values and frame geometry
// for the slot content placement block.
// Assumes inclusion by bare name from every file that needs it.
`ifndef TSCP_MAP_SVH
`define TSCP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets on the control port
// ----------------------------------------------------------------------
`define TSCP_ADDR_P4        8'h27
`define TSCP_ADDR_P5        8'h28
`define TSCP_ADDR_P6        8'h29
`define TSCP_ADDR_LG1       8'h2a

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TSCP_DAC_LSB        4
`define TSCP_SNS_LSB        0
`define TSCP_LG_OFS_LSB     5
`define TSCP_LG_SLOT_LSB    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TSCP_RST_PLACEMENT4_INPUT_WIDTH     2'h2
`define TSCP_RST_PLACEMENT4_SENSE_CODE     4'h1
`define TSCP_RST_PLACEMENT5_SENSE_CODE     4'h1
`define TSCP_RST_PLACEMENT6_SENSE_CODE     4'h1
`define TSCP_RST_LG_OFS     3'h0
`define TSCP_RST_LG_SLOT    5'h0

// ----------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------
`define TSCP_SLOT_BITS      64
`define TSCP_FRAME_SLOTS    32
`define TSCP_LG_OFS_TOP     54
`define TSCP_GAIN_BITS      8

`endif

/* File: rtl/tscp_pair_buf.sv */
// Small word buffer with valid/ready on both sides.
// Assumes synchronous active-low reset already released cleanly.
`default_nettype none

module tscp_pair_buf #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Streams
    tscp_stream_if.snk  up,
    tscp_stream_if.src  dn
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2) begin : g_chk
        $error("tscp_pair_buf needs DEPTH of at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wp_ff;
    logic [PW-1:0]    rp_ff;
    logic [PW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign up.ready = (cnt_ff != (PW+1)'(DEPTH));
    assign dn.valid = (cnt_ff != '0);
    assign dn.data  = mem_ff[rp_ff];
    assign push     = up.valid & up.ready;
    assign pop      = dn.valid & dn.ready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (push) begin
            mem_ff[wp_ff] <= up.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + PW'(1);
            end
            if (pop) begin
                rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (push && !pop) begin
            cnt_ff <= cnt_ff + (PW+1)'(1);
        end else if (pop && !push) begin
            cnt_ff <= cnt_ff - (PW+1)'(1);
        end
    end

endmodule

`default_nettype wire

/* File: rtl/tscp_pkg.sv */
// Types shared by the slot content placement block.
// Assumes nothing of its surroundings.
`default_nettype none

package tscp_pkg;

    typedef enum logic [3:0] {
        SNS_VOLT    = 4'h0,
        SNS_CURR    = 4'h1,
        SNS_BATT    = 4'h2,
        SNS_GAIN    = 4'h3,
        SNS_ALT     = 4'h4,
        SNS_STAT    = 4'h5,
        SNS_MARK    = 4'h6,
        SNS_TEMP    = 4'h7,
        SNS_BLANK   = 4'h8
    } tscp_sense_e;

    typedef enum logic [1:0] {
        DAC_W24     = 2'h0,
        DAC_W16     = 2'h1,
        DAC_NONE_A  = 2'h2,
        DAC_NONE_B  = 2'h3
    } tscp_dac_e;

endpackage

`default_nettype wire

/* File: rtl/tscp_stream_if.sv */
// Valid/ready word stream between the receive path and its buffer.
// Assumes both ends run on the same clock.
`default_nettype none

interface tscp_stream_if #(
    parameter int W = 24
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: rtl/tscp_top.sv */
// Slot content placement: sense words out of the own chip slot,
// DAC word and linked limiter gain in from the frame.
// Assumes link pins asynchronous to clk and bclk well below clk / 4.
`include "tscp_map.svh"
`default_nettype none

// Functional notes
// - DAC code 00 24-bit, 01 16-bit, else unused
// - Codes 0,1 voltage/current 16; 4 alternates both
// - Code 2 battery byte, code 3 gain byte
// - Codes 5,6,7,8 status, marker, temperature, blank
// - Placement 4 sense field bits 3:0, reset 1
// - Placement 5 sense only, bits 7:4 read zero
// - Placement 6 sense only, upper nibble reads zero
// - Slot field code n selects slot n
// - Offset code times eight up to bit 48
// - Offset code 7 starts gain at bit 54
// - Linked gain placement register resets to zero
module tscp_top #(
    parameter int SLOT_BITS   = `TSCP_SLOT_BITS,
    parameter int FRAME_SLOTS = `TSCP_FRAME_SLOTS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Serial link pins
    input  wire logic        bclk,
    input  wire logic        fsync,
    input  wire logic        sdin,
    output logic             sdout_o,
    output logic             sdout_oe,
    // Own chip slot geometry
    input  wire logic [4:0]  own_slot,
    input  wire logic [5:0]  p4_start,
    // Sense data
    input  wire logic [15:0] sense_voltage,
    input  wire logic [15:0] sense_current,
    input  wire logic [7:0]  battery_level,
    input  wire logic [7:0]  limiter_gain_value,
    input  wire logic [7:0]  status_bits,
    input  wire logic [7:0]  temperature,
    // Received DAC words
    output logic      [23:0] dac_word,
    output logic             dac_valid,
    input  wire logic        dac_ready,
    output logic             dac_overrun,
    // Linked limiter gain
    output logic      [7:0]  linked_gain,
    output logic             linked_gain_valid
);
    localparam int CNT_W = $clog2(SLOT_BITS * FRAME_SLOTS);
    localparam int SB_W  = $clog2(SLOT_BITS);

    if (SLOT_BITS != `TSCP_SLOT_BITS || FRAME_SLOTS < `TSCP_FRAME_SLOTS)
    begin : g_chk
        $error("tscp_top needs 64-bit slots and at least 32 slots");
    end

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sh_ff;
    logic       rst_n;
    logic [2:0] bclk_ff;
    logic [1:0] fs_ff;
    logic [1:0] sd_ff;
    logic       fs_seen_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sh_ff <= 2'h0;
        end else begin
            rst_sh_ff <= {rst_sh_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sh_ff[1];

    always_ff @(posedge clk) begin
        bclk_ff <= {bclk_ff[1:0], bclk};
        fs_ff   <= {fs_ff[0], fsync};
        sd_ff   <= {sd_ff[0], sdin};
    end

    logic rise;
    logic fall;
    logic frame_start;
    assign rise        = bclk_ff[1] & ~bclk_ff[2];
    assign fall        = ~bclk_ff[1] & bclk_ff[2];
    assign frame_start = rise & fs_ff[1] & ~fs_seen_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_seen_ff <= 1'b0;
        end else if (rise) begin
            fs_seen_ff <= fs_ff[1];
        end
    end

    // ------------------------------------------------------------------
    // Bit position in frame
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] idx;
    assign idx = frame_start ? '0 : cnt_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (rise) begin
            cnt_ff <= idx + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0] placement4_input_width_ff;
    logic [3:0] placement4_sense_code_ff;
    logic [3:0] placement5_sense_code_ff;
    logic [3:0] placement6_sense_code_ff;
    logic [2:0] lg_ofs_ff;
    logic [4:0] lg_slot_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            placement4_input_width_ff  <= `TSCP_RST_PLACEMENT4_INPUT_WIDTH;
            placement4_sense_code_ff  <= `TSCP_RST_PLACEMENT4_SENSE_CODE;
            placement5_sense_code_ff  <= `TSCP_RST_PLACEMENT5_SENSE_CODE;
            placement6_sense_code_ff  <= `TSCP_RST_PLACEMENT6_SENSE_CODE;
            lg_ofs_ff  <= `TSCP_RST_LG_OFS;
            lg_slot_ff <= `TSCP_RST_LG_SLOT;
        end else if (reg_wr) begin
            case (reg_addr)
                `TSCP_ADDR_P4: begin
                    placement4_input_width_ff <= reg_wdata[`TSCP_DAC_LSB +: 2];
                    placement4_sense_code_ff <= reg_wdata[`TSCP_SNS_LSB +: 4];
                end
                `TSCP_ADDR_P5: placement5_sense_code_ff <= reg_wdata[`TSCP_SNS_LSB +: 4];
                `TSCP_ADDR_P6: placement6_sense_code_ff <= reg_wdata[`TSCP_SNS_LSB +: 4];
                `TSCP_ADDR_LG1: begin
                    lg_ofs_ff  <= reg_wdata[`TSCP_LG_OFS_LSB +: 3];
                    lg_slot_ff <= reg_wdata[`TSCP_LG_SLOT_LSB +: 5];
                end
                default: ;
            endcase
        end
    end

    // Reserved bits and unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TSCP_ADDR_P4:  reg_rdata <= {2'h0, placement4_input_width_ff, placement4_sense_code_ff};
                `TSCP_ADDR_P5:  reg_rdata <= {4'h0, placement5_sense_code_ff};
                `TSCP_ADDR_P6:  reg_rdata <= {4'h0, placement6_sense_code_ff};
                `TSCP_ADDR_LG1: reg_rdata <= {lg_ofs_ff, lg_slot_ff};
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit content, latched once per frame
    // ------------------------------------------------------------------
    logic             alt_ff;
    logic [3:0]       code [3];
    logic [15:0]      pl_data_ff [3];
    logic [4:0]       pl_w_ff [3];

    assign code[0] = placement4_sense_code_ff;
    assign code[1] = placement5_sense_code_ff;
    assign code[2] = placement6_sense_code_ff;

    function automatic logic [15:0] sns_data(input logic [3:0] c,
                                             input logic       cur);
        case (tscp_pkg::tscp_sense_e'(c))
            tscp_pkg::SNS_VOLT:  return sense_voltage;
            tscp_pkg::SNS_CURR:  return sense_current;
            tscp_pkg::SNS_BATT:  return {battery_level, 8'h00};
            tscp_pkg::SNS_GAIN:  return {limiter_gain_value, 8'h00};
            tscp_pkg::SNS_ALT:   return cur ? sense_current : sense_voltage;
            tscp_pkg::SNS_STAT:  return {status_bits, 8'h00};
            tscp_pkg::SNS_MARK:  return {cur, status_bits[6:0], 8'h00};
            tscp_pkg::SNS_TEMP:  return {temperature, 8'h00};
            default:             return 16'h0000;
        endcase
    endfunction

    function automatic logic [4:0] sns_width(input logic [3:0] c);
        case (tscp_pkg::tscp_sense_e'(c))
            tscp_pkg::SNS_VOLT, tscp_pkg::SNS_CURR,
            tscp_pkg::SNS_ALT:   return 5'h10;
            default:             return 5'h08;
        endcase
    endfunction

    // Marker bit tells which half of the alternation this frame carries
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_ff <= 1'b0;
        end else if (frame_start) begin
            alt_ff <= ~alt_ff;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_pl
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pl_data_ff[g] <= 16'h0000;
                pl_w_ff[g]    <= 5'h08;
            end else if (frame_start) begin
                pl_data_ff[g] <= sns_data(code[g], alt_ff);
                pl_w_ff[g]    <= sns_width(code[g]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit bit select, launched on falling bclk
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] own_base;
    logic [CNT_W-1:0] rel_tx;
    logic [5:0]       e0;
    logic [5:0]       e1;
    logic [5:0]       e2;
    logic [3:0]       r0;
    logic [3:0]       r1;
    logic [3:0]       r2;
    logic             nxt_sdout;
    logic             nxt_oe;
    logic             sdout_ff;
    logic             oe_ff;

    assign own_base = CNT_W'({own_slot, SB_W'(0)}) + CNT_W'(p4_start);
    assign rel_tx   = cnt_ff - own_base;
    assign e0 = 6'(pl_w_ff[0]);
    assign e1 = e0 + 6'(pl_w_ff[1]);
    assign e2 = e1 + 6'(pl_w_ff[2]);
    assign r0 = ~4'(rel_tx);
    assign r1 = ~4'(rel_tx - CNT_W'(e0));
    assign r2 = ~4'(rel_tx - CNT_W'(e1));

    always_comb begin
        nxt_sdout = 1'b0;
        nxt_oe    = 1'b1;
        if (cnt_ff < own_base) begin
            nxt_oe = 1'b0;
        end else if (rel_tx < CNT_W'(e0)) begin
            nxt_sdout = pl_data_ff[0][r0];
        end else if (rel_tx < CNT_W'(e1)) begin
            nxt_sdout = pl_data_ff[1][r1];
        end else if (rel_tx < CNT_W'(e2)) begin
            nxt_sdout = pl_data_ff[2][r2];
        end else begin
            nxt_oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdout_ff <= 1'b0;
            oe_ff    <= 1'b0;
        end else if (fall) begin
            sdout_ff <= nxt_sdout;
            oe_ff    <= nxt_oe;
        end
    end
    assign sdout_o  = sdout_ff;
    assign sdout_oe = oe_ff;

    // ------------------------------------------------------------------
    // DAC word capture into the buffer
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] rel_rx;
    logic [4:0]       dac_bits;
    logic [23:0]      dac_sh_ff;
    logic [23:0]      nxt_sh;
    logic             push_ff;
    logic [23:0]      push_data_ff;
    logic             ovr_ff;
    logic             dac_cap;

    assign rel_rx   = idx - own_base;
    assign dac_bits = (placement4_input_width_ff == tscp_pkg::DAC_W24) ? 5'd24 : 5'd16;
    assign nxt_sh   = {dac_sh_ff[22:0], sd_ff[1]};
    assign dac_cap  = rise && !placement4_input_width_ff[1] && idx >= own_base
                      && rel_rx < CNT_W'(dac_bits);

    tscp_stream_if #(.W(24)) push_if ();
    tscp_stream_if #(.W(24)) pop_if ();

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_sh_ff    <= 24'h000000;
            push_ff      <= 1'b0;
            push_data_ff <= 24'h000000;
            ovr_ff       <= 1'b0;
        end else begin
            push_ff <= 1'b0;
            ovr_ff  <= push_ff & ~push_if.ready;
            if (dac_cap) begin
                dac_sh_ff <= nxt_sh;
                if (rel_rx == CNT_W'(dac_bits - 5'd1)) begin
                    push_ff      <= 1'b1;
                    push_data_ff <= placement4_input_width_ff[0] ?
                                    {nxt_sh[15:0], 8'h00} : nxt_sh;
                end
            end
        end
    end

    // A serial link cannot be stalled: a word meeting a full buffer is
    // dropped and flagged instead
    assign push_if.valid = push_ff;
    assign push_if.data  = push_data_ff;
    assign pop_if.ready  = dac_ready;
    assign dac_valid     = pop_if.valid;
    assign dac_word      = pop_if.data;
    assign dac_overrun   = ovr_ff;

    tscp_pair_buf #(.WIDTH(24), .DEPTH(2)) u_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .up    (push_if),
        .dn    (pop_if)
    );

    // ------------------------------------------------------------------
    // Linked limiter gain capture
    // ------------------------------------------------------------------
    logic [SB_W-1:0]  lg_pos;
    logic [CNT_W-1:0] gain_first;
    logic [CNT_W-1:0] gain_last;
    logic [6:0]       gain_sh_ff;

    assign lg_pos = (lg_ofs_ff == 3'h7) ? SB_W'(`TSCP_LG_OFS_TOP)
                                        : SB_W'({lg_ofs_ff, 3'h0});
    assign gain_first = CNT_W'({lg_slot_ff, SB_W'(0)})
                        + CNT_W'(lg_pos);
    assign gain_last  = gain_first + CNT_W'(`TSCP_GAIN_BITS - 1);

    // Relies on the linked party placing its gain here, MSB first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_sh_ff        <= 7'h00;
            linked_gain       <= 8'h00;
            linked_gain_valid <= 1'b0;
        end else begin
            linked_gain_valid <= 1'b0;
            if (rise && idx >= gain_first && idx <= gain_last) begin
                gain_sh_ff <= {gain_sh_ff[5:0], sd_ff[1]};
                if (idx == gain_last) begin
                    linked_gain       <= {gain_sh_ff, sd_ff[1]};
                    linked_gain_valid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_dac_push_code: assert property (
        push_ff |-> !$past(placement4_input_width_ff[1]) &&
        (!$past(placement4_input_width_ff[0]) || push_data_ff[7:0] == 8'h00))
        else $error("DAC word pushed against width code");
    a_curr_sense: assert property (
        frame_start && placement4_sense_code_ff == 4'h1 |=>
        pl_w_ff[0] == 5'h10 && pl_data_ff[0] == $past(sense_current))
        else $error("current code did not load 16-bit current");
    a_batt_byte: assert property (
        frame_start && placement5_sense_code_ff == 4'h2 |=> pl_w_ff[1] == 5'h08 &&
        pl_data_ff[1] == {$past(battery_level), 8'h00})
        else $error("battery code did not load battery byte");
    a_blank_byte: assert property (
        frame_start && placement6_sense_code_ff == 4'h8 |=>
        pl_w_ff[2] == 5'h08 && pl_data_ff[2] == 16'h0000)
        else $error("blank code did not load blank byte");
    a_p4_reset: assert property (
        $rose(rst_n) |-> placement4_sense_code_ff == 4'h1 && placement4_input_width_ff == 2'h2)
        else $error("placement 4 reset value wrong");
    a_p5_rsvd: assert property (
        reg_rd && reg_addr == `TSCP_ADDR_P5 |=> reg_rdata[7:4] == 4'h0)
        else $error("placement 5 reserved bits not zero");
    a_p6_rsvd: assert property (
        reg_rd && reg_addr == `TSCP_ADDR_P6 |=>
        reg_rdata == {4'h0, $past(placement6_sense_code_ff)})
        else $error("placement 6 readback wrong");
    a_gain_slot: assert property (
        linked_gain_valid |->
        $past(idx[CNT_W-1:SB_W]) == $past(lg_slot_ff))
        else $error("linked gain taken from wrong slot");
    a_gain_ofs: assert property (
        linked_gain_valid && $past(lg_ofs_ff) != 3'h7 |->
        $past(idx[SB_W-1:0]) == SB_W'({$past(lg_ofs_ff), 3'h7}))
        else $error("linked gain taken at wrong offset");
    a_gain_top: assert property (
        linked_gain_valid && $past(lg_ofs_ff) == 3'h7 |->
        $past(idx[SB_W-1:0]) == SB_W'(61))
        else $error("offset code 7 not at bit 54");
    a_lg_reset: assert property (
        $rose(rst_n) |-> lg_ofs_ff == 3'h0 && lg_slot_ff == 5'h0)
        else $error("linked gain placement reset wrong");
    a_tx_order: assert property (
        fall && cnt_ff >= own_base && rel_tx == CNT_W'(e0) |=>
        sdout_oe && sdout_o == pl_data_ff[1][15])
        else $error("placement 5 did not follow placement 4");

    c_gain_rx: cover property (linked_gain_valid);
    c_dac16: cover property (push_ff && placement4_input_width_ff == 2'h1);
    c_buf_full: cover property (!push_if.ready);
    c_alt_tx: cover property (frame_start && placement4_sense_code_ff == 4'h4 && alt_ff);

endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// Bench: register access, six link frames, DAC buffer fill and drain.
// Assumes the design files and the host model are compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         dac_ready = 1'b0;
    logic [4:0]   own_slot = 5'h01;
    logic [5:0]   p4_start = 6'h00;
    logic [15:0]  sense_voltage = 16'h9a3c;
    logic [15:0]  sense_current = 16'h5e71;
    logic [7:0]   battery_level = 8'hc4;
    logic [7:0]   limiter_gain_value = 8'h3b;
    logic [7:0]   status_bits = 8'h96;
    logic [7:0]   temperature = 8'h2d;
    logic [7:0]   reg_rdata, linked_gain, ovr = 8'h00, gv = 8'h00;
    logic [23:0]  dac_word;
    logic         sdout_o, sdout_oe, dac_valid, dac_overrun;
    logic         linked_gain_valid, bclk, fsync, sdin;
    logic [191:0] tx, rx, oe;
    int           err_count = 0;
    int           checks = 0;
    int           cyc = 0;

    tscp_top uut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .bclk, .fsync, .sdin, .sdout_o, .sdout_oe, .own_slot,
        .p4_start, .sense_voltage, .sense_current, .battery_level,
        .limiter_gain_value, .status_bits, .temperature, .dac_word,
        .dac_valid, .dac_ready, .dac_overrun, .linked_gain,
        .linked_gain_valid);
    tscp_host_model host (.bclk, .fsync, .sdin, .sdout_o, .sdout_oe);

    initial forever #12.5 clk = ~clk;

    task automatic close_out();
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic cfg(input logic [7:0] p4, p5, p6, lg);
        wr(8'h27, p4);
        wr(8'h28, p5);
        wr(8'h29, p6);
        wr(8'h2a, lg);
    endtask
    task automatic run_frame(input logic [23:0] w);
        tx[127-:24] = w;
        host.frame(tx, rx, oe);
        repeat (20) @(posedge clk);
    endtask
    task automatic pop(input logic [23:0] w);
        chk({dac_valid, dac_word}, {1'b1, w});
        @(posedge clk);
        dac_ready <= 1'b1;
        @(posedge clk);
        dac_ready <= 1'b0;
        #1;
    endtask

    // Overrun is a one-cycle pulse, so it is counted rather than polled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (dac_overrun === 1'b1) ovr <= ovr + 8'h01;
        if (linked_gain_valid === 1'b1) gv <= gv + 8'h01;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        tx = 192'h0;
        tx[191-:8] = 8'he5;
        tx[183-:8] = 8'h4d;
        tx[9-:8] = 8'h7c;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(8'h27, 8'h21);
        rdc(8'h28, 8'h01);
        rdc(8'h29, 8'h01);
        rdc(8'h2a, 8'h00);
        rdc(8'h30, 8'h00);
        wr(8'h28, 8'hf3);
        rdc(8'h28, 8'h03);
        wr(8'h29, 8'ha7);
        rdc(8'h29, 8'h07);
        wr(8'h27, 8'hc4);
        rdc(8'h27, 8'h04);
        cfg(8'h04, 8'h02, 8'h03, 8'h00);
        run_frame(24'ha1b2c3);
        chk(rx[127-:16], sense_voltage);
        chk(rx[111-:8], battery_level);
        chk(rx[103-:8], limiter_gain_value);
        chk({oe[128], oe[127-:32], oe[95]}, {1'b0, 32'hffffffff, 1'b0});
        chk(linked_gain, 8'he5);
        cfg(8'h04, 8'h01, 8'h03, 8'he2);
        rdc(8'h2a, 8'he2);
        run_frame(24'hd4e5f6);
        chk(rx[127-:16], sense_current);
        chk(rx[111-:16], sense_current);
        chk(linked_gain, 8'h7c);
        cfg(8'h15, 8'h07, 8'h08, 8'h20);
        run_frame(24'h135700);
        chk(rx[127-:8], status_bits);
        chk(rx[119-:8], temperature);
        chk({oe[128], oe[127-:24], oe[103]}, {1'b0, 24'hffffff, 1'b0});
        chk(linked_gain, 8'h4d);
        chk(ovr, 8'h01);
        pop(24'ha1b2c3);
        pop(24'hd4e5f6);
        chk(dac_valid, 1'b0);
        for (int c = 1; c < 4; c++) begin
            cfg({2'b00, c[1:0], 4'h8}, 8'h00, 8'h06, 8'h20);
            p4_start <= (c == 3) ? 6'h08 : 6'h00;
            run_frame(24'h2468ac);
            chk(rx[119 - p4_start -: 16], sense_voltage);
            chk(rx[103 - p4_start -: 8], {c[0], status_bits[6:0]});
            chk(oe[127 -: 8], (c == 3) ? 8'h00 : 8'hff);
            if (c == 1) pop(24'h246800);
            chk(dac_valid, 1'b0);
        end
        chk(gv, 8'h06);
        close_out();
    end
endmodule
`default_nettype wire

/* File: tb/tscp_host_model.sv */
// Host end of the serial link: bit clock, frame sync and data in.
// Assumes the bench calls frame() only while the link is idle.
`default_nettype none
module tscp_host_model (
    // Link pins
    output logic      bclk,
    output logic      fsync,
    output logic      sdin,
    input  wire logic sdout_o,
    input  wire logic sdout_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        sdin = 1'b0;
    end
    // Frame bit i sits at index 191-i; the clock stops between frames
    task automatic frame(input logic [191:0] tx, output logic [191:0] rx,
                         output logic [191:0] oe);
        // Start off the clk edge so pin changes never race the sampling
        #5;
        for (int i = 0; i < 192; i++) begin
            bclk = 1'b0;
            fsync = (i == 0);
            sdin = tx[191-i];
            #100 bclk = 1'b1;
            // Late in the period so the resynchronised output has landed
            #90 rx[191-i] = sdout_o;
            oe[191-i] = sdout_oe;
            #10;
        end
        bclk = 1'b0;
        fsync = 1'b0;
        sdin = ~sdin;
    endtask
endmodule
`default_nettype wire
